// ===== rtl/tsm_top.sv
// tsm_top: monitors that the safety shutdown circuits are test-stopped in time
// assumes one 20 MHz clock, power-on reset, intervals in seconds from config ports
// Function
// - extended countdown readable; extended test-due alarm at its end
// - basic countdown readable; basic test-due alarm once expired
// - extended expiry shown as a routable output bit
// - basic alarm appears in bit 31 of safety status word
// - alarms are informational and never stop or limit the motor
// - running a test stop internally selects safe torque off
// - extended test starts on selection signal or optionally at power-on
// - extended test stop checks extended and basic circuits
// - basic circuits tested after power-on, on safe torque off or stop one, in extended test
`timescale 1ns/10ps
module tsm_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] ext_monitor_interval,
  input wire logic [31:0] basic_monitor_interval,
  input wire logic ext_enable,
  input wire logic auto_test_power_on,
  input wire logic test_select,
  input wire logic safe_torque_off,
  input wire logic safe_stop_one,
  input wire logic circuit_ok,
  input wire logic [30:0] safety_status_in,
  output logic [31:0] ext_remaining_time,
  output logic [31:0] basic_remaining_time,
  output logic ext_test_due_alarm,
  output logic basic_test_due_alarm,
  output logic ext_timer_expiry_bit,
  output logic [31:0] safety_status_word,
  output logic test_sto_select,
  output logic test_busy,
  output logic test_failed
);
  typedef struct packed {
    logic [2:0] sel_sync;
    logic [2:0] sto_sync;
    logic [2:0] ss1_sync;
    logic [1:0] ok_sync;
    logic power_on;
    tsm_pkg::tsm_state_e state;
    logic [7:0] test_cnt;
    logic [24:0] tick_cnt;
    logic tick;
    logic reload_ext;
    logic reload_basic;
    logic ext_alarm;
    logic basic_alarm;
    logic [31:0] status;
    logic sto_sel;
    logic busy;
    logic failed;
  } tsm_top_s;
  tsm_top_s q;
  tsm_top_s next_q;
  logic [31:0] ext_rem;
  logic [31:0] basic_rem;
  logic ext_exp;
  logic basic_exp;

  // extended countdown
  tsm_countdown u_ext (
    .clk(clk),
    .rst_n(rst_n),
    .tick(q.tick),
    .reload(q.reload_ext),
    .interval(ext_monitor_interval),
    .remaining(ext_rem),
    .expired(ext_exp)
  );

  // basic countdown
  tsm_countdown u_basic (
    .clk(clk),
    .rst_n(rst_n),
    .tick(q.tick),
    .reload(q.reload_basic),
    .interval(basic_monitor_interval),
    .remaining(basic_rem),
    .expired(basic_exp)
  );

  always_comb begin
    next_q = q;
    next_q.reload_ext = 1'b0;
    next_q.reload_basic = 1'b0;
    next_q.tick = 1'b0;
    // pins pass three flops (circuit_ok two); only the later stages feed edge detection
    next_q.sel_sync = {q.sel_sync[1:0], test_select};
    next_q.sto_sync = {q.sto_sync[1:0], safe_torque_off};
    next_q.ss1_sync = {q.ss1_sync[1:0], safe_stop_one};
    next_q.ok_sync = {q.ok_sync[0], circuit_ok};
    // one-second enable; yearly intervals fit easily in 32 bits of seconds
    if (q.tick_cnt == 25'(tsm_pkg::tsm_tick_cycles - 1)) begin
      next_q.tick_cnt = '0;
      next_q.tick = 1'b1;
    end else begin
      next_q.tick_cnt = q.tick_cnt + 25'h000_0001;
    end
    // test sequencer: a fixed check window, then judge the circuits
    case (q.state)
      tsm_pkg::tsm_idle: begin
        next_q.sto_sel = 1'b0;
        next_q.test_cnt = '0;
        if (ext_enable && ((q.sel_sync[2:1] == 2'b01) || (q.power_on && auto_test_power_on))) begin
          next_q.state = tsm_pkg::tsm_test_ext;
          next_q.sto_sel = 1'b1;
        end else if (q.power_on || q.sto_sync[2:1] == 2'b01 || q.ss1_sync[2:1] == 2'b01) begin
          next_q.state = tsm_pkg::tsm_test_basic;
          next_q.sto_sel = 1'b1;
        end
        next_q.power_on = 1'b0;
      end
      tsm_pkg::tsm_test_ext, tsm_pkg::tsm_test_basic: begin
        next_q.test_cnt = q.test_cnt + 8'h01;
        if (q.test_cnt == tsm_pkg::tsm_test_cycles) begin
          next_q.state = tsm_pkg::tsm_idle;
          next_q.sto_sel = 1'b0;
          next_q.failed = ~q.ok_sync[1];
          if (q.ok_sync[1]) begin
            next_q.reload_basic = 1'b1;
            next_q.reload_ext = (q.state == tsm_pkg::tsm_test_ext);
          end
        end
      end
      default: begin
        next_q.state = tsm_pkg::tsm_idle;
      end
    endcase
    // alarms only report; nothing here touches the drive path
    next_q.ext_alarm = ext_exp & ext_enable;
    next_q.basic_alarm = basic_exp;
    next_q.status = {basic_exp, safety_status_in};
    // busy kept in its own flop so the port is not a state decode
    next_q.busy = (next_q.state != tsm_pkg::tsm_idle) ? 1'b1 : 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.power_on <= 1'b1;
      q.state <= tsm_pkg::tsm_idle;
    end else begin
      q <= next_q;
    end
  end

  // registered outputs; remaining times come from counter flops directly
  assign ext_remaining_time = ext_rem;
  assign basic_remaining_time = basic_rem;
  assign ext_test_due_alarm = q.ext_alarm;
  assign basic_test_due_alarm = q.basic_alarm;
  assign ext_timer_expiry_bit = q.ext_alarm;
  assign safety_status_word = q.status;
  assign test_sto_select = q.sto_sel;
  assign test_busy = q.busy;
  assign test_failed = q.failed;
endmodule : tsm_top

// ===== rtl/tsm_pkg.sv
// tsm_pkg: shared constants for the test stop monitor
// assumes a 20 MHz clock and a one-second tick derived from it
package tsm_pkg;
  localparam int unsigned tsm_clk_hz = 20_000_000;
  localparam int unsigned tsm_tick_s = 1;
  localparam int unsigned tsm_tick_cycles = tsm_clk_hz * tsm_tick_s;
  localparam int tsm_time_w = 32;
  localparam int tsm_tick_w = 25;
  localparam int tsm_test_w = 8;
  localparam logic [7:0] tsm_test_cycles = 8'h10;
  localparam int tsm_alarm_bit = 31;
  localparam logic [31:0] tsm_time_max = 32'hFFFF_FFFF;
  localparam logic [31:0] tsm_time_rst = 32'h0000_0000;
  typedef enum logic [1:0] {tsm_idle, tsm_test_ext, tsm_test_basic} tsm_state_e;
endpackage : tsm_pkg

// ===== rtl/tsm_countdown.sv
// tsm_countdown: one remaining-time counter with sticky expiry
// assumes tick is a one-cycle enable and reload wins over counting
`timescale 1ns/10ps
module tsm_countdown (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic reload,
  input wire logic [31:0] interval,
  output logic [31:0] remaining,
  output logic expired
);
  typedef struct packed {
    logic [31:0] remaining;
    logic expired;
  } tsm_cd_s;
  tsm_cd_s q;
  tsm_cd_s next_q;

  // reload on a passed test, otherwise count down and latch expiry at zero
  always_comb begin
    next_q = q;
    if (reload) begin
      next_q.remaining = interval;
      next_q.expired = 1'b0;
    end else if (tick && q.remaining != tsm_pkg::tsm_time_rst) begin
      next_q.remaining = q.remaining - 32'h0000_0001;
      if (q.remaining == 32'h0000_0001) begin
        next_q.expired = 1'b1;
      end
    end else if (q.remaining == tsm_pkg::tsm_time_rst) begin
      next_q.expired = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign remaining = q.remaining;
  assign expired = q.expired;
endmodule : tsm_countdown

// ===== tb/tsm_checker.sv
// tsm_checker: port assertions for tsm_top
// assumes one clock and async active-low reset
`timescale 1ns/10ps
module tsm_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic safe_torque_off,
  input wire logic safe_stop_one,
  input wire logic [31:0] basic_monitor_interval,
  input wire logic [31:0] basic_remaining_time,
  input wire logic basic_test_due_alarm,
  input wire logic [31:0] safety_status_word,
  input wire logic test_sto_select,
  input wire logic test_busy,
  input wire logic test_failed
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a test is exactly 17 busy cycles, then the reload lands
  sequence s_busy8; test_busy [*8]; endsequence
  sequence s_load; ##1 basic_remaining_time == basic_monitor_interval ##1 !basic_test_due_alarm; endsequence
  property p_sto; test_sto_select == test_busy; endproperty
  a_sto: assert property (p_sto) else $error("sto select");
  property p_len; $rose(test_busy) |-> s_busy8 ##1 s_busy8 ##1 test_busy ##1 !test_busy; endproperty
  a_len: assert property (p_len) else $error("test length");
  property p_pass; $fell(test_busy) && !test_failed |-> s_load; endproperty
  a_pass: assert property (p_pass) else $error("no reload");
  property p_fail; $fell(test_busy) && test_failed |-> ##1 $stable(basic_remaining_time); endproperty
  a_fail: assert property (p_fail) else $error("fail reload");
  property p_calm; basic_test_due_alarm && !test_busy |-> !test_sto_select; endproperty
  a_calm: assert property (p_calm) else $error("alarm stops");
  property p_bit31; basic_test_due_alarm && $past(basic_test_due_alarm) |-> safety_status_word[31]; endproperty
  a_bit31: assert property (p_bit31) else $error("bit 31");
  property p_sto_pin; $rose(safe_torque_off) && !test_busy |-> ##[3:5] test_busy; endproperty
  a_sto_pin: assert property (p_sto_pin) else $error("sto test");
  property p_ss1_pin; $rose(safe_stop_one) && !test_busy |-> ##[3:5] test_busy; endproperty
  a_ss1_pin: assert property (p_ss1_pin) else $error("ss1 test");
endmodule : tsm_checker
bind tsm_top tsm_checker u_chk (.*);

// ===== tb/tsm_ctrl_model.sv
// tsm_ctrl_model: controller answering the extended alarm
// assumes arm is a one-cycle go and busy marks a test
`timescale 1ns/10ps
module tsm_ctrl_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic arm,
  input wire logic alarm,
  input wire logic busy,
  output logic test_select
);
  // request held until the test runs, so its edge is never lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) test_select <= 1'b0;
    else if (busy) test_select <= 1'b0;
    else if (arm && alarm) test_select <= 1'b1;
  end
endmodule : tsm_ctrl_model

// ===== tb/tsm_top_bench.sv
// tsm_top_bench: directed test stop scenarios
// assumes no one-second tick elapses in this short run
`timescale 1ns/10ps
module tsm_top_bench;
  logic clk = 1'b0, rst_n = 1'b0, ext_enable = 1'b0, arm = 1'b0, circuit_ok = 1'b1;
  logic auto_test_power_on = 1'b0, safe_torque_off = 1'b0, safe_stop_one = 1'b0;
  logic [31:0] ext_monitor_interval = 32'h0000_0002, basic_monitor_interval = 32'h0000_0003;
  logic [30:0] safety_status_in = 31'h1234_5678;
  logic [31:0] ext_remaining_time, basic_remaining_time, safety_status_word;
  logic test_select, ext_test_due_alarm, basic_test_due_alarm, ext_timer_expiry_bit;
  logic test_sto_select, test_busy, test_failed;
  int failures = 0, comparisons = 0;
  always #25 clk = ~clk;
  tsm_top dut (.*);
  tsm_ctrl_model ctrl (.clk, .rst_n, .arm, .alarm(ext_test_due_alarm), .busy(test_busy), .test_select);
  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) failures++;
    if (got !== exp) $display("wrong value %0t %h %h", $time, got, exp);
  endtask : chk
  // one whole test, bounded so a hang still ends the run
  task automatic run_test;
    int i;
    for (i = 0; i < 90 && test_busy !== 1'b1; i++) @(posedge clk);
    for (i = i; i < 90 && test_busy !== 1'b0; i++) @(posedge clk);
    if (i >= 90) failures++;
    if (i >= 90) tally_and_finish();
    repeat (5) @(posedge clk);
  endtask : run_test
  task automatic pulse(input logic stop);
    safe_stop_one <= stop;
    safe_torque_off <= !stop;
    repeat (5) @(posedge clk);
    {safe_stop_one, safe_torque_off} <= 2'b00;
    run_test();
  endtask : pulse
  // power-on test, zero interval expiry, a failing test, then a passing one
  task automatic s_basic;
    rst_n <= 1'b1;
    run_test();
    chk(basic_remaining_time, 32'h0000_0003);
    basic_monitor_interval <= 32'h0000_0000;
    pulse(1'b1);
    chk(safety_status_word, {1'b1, safety_status_in});
    chk(32'({basic_test_due_alarm, test_sto_select}), 32'h0000_0002);
    circuit_ok <= 1'b0;
    basic_monitor_interval <= 32'h0000_0003;
    pulse(1'b0);
    chk(32'(test_failed), 32'h0000_0001);
    circuit_ok <= 1'b1;
    pulse(1'b0);
    chk(basic_remaining_time, 32'h0000_0003);
  endtask : s_basic
  // extended use: controller answers the alarm, both timers reload
  task automatic s_ext;
    ext_enable <= 1'b1;
    basic_monitor_interval <= 32'hFFFF_FFFF;
    repeat (4) @(posedge clk);
    chk(32'(ext_timer_expiry_bit), 32'h0000_0001);
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    run_test();
    chk(ext_remaining_time, 32'h0000_0002);
    chk(basic_remaining_time, 32'hFFFF_FFFF);
    chk(32'(ext_test_due_alarm), 32'h0000_0000);
  endtask : s_ext
  // mid-run reset with automatic extended test at power-on
  task automatic s_auto;
    auto_test_power_on <= 1'b1;
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    run_test();
    chk(ext_remaining_time, 32'h0000_0002);
    chk(32'(ext_test_due_alarm), 32'h0000_0000);
  endtask : s_auto
  initial begin
    repeat (20) @(posedge clk);
    s_basic();
    s_ext();
    s_auto();
    tally_and_finish();
  end
endmodule : tsm_top_bench
